// >>> dv/eeprom_cmd_write_tb.sv
// self-checking bench for the eeprom command and write block
`timescale 1ns/1ps
module eeprom_cmd_write_tb;
  import eep_pkg::*;
  localparam int WR = 50;
  localparam int DS = 8;
  // arbitrary factory and identification values
  localparam logic [127:0] FACT = 128'hA1B2C3D4E5F60718293A4B5C6D7E8F90;
  localparam logic [23:0]  IDV  = 24'h3C5A96;
  logic       clk_sys, reset, fs, fp, bv, bval, sio, ans, rgo, busy, lck, frz, a;
  logic [3:0] rop, rd_op, zrom;
  logic [7:0] rd_addr, ak;
  byte_t      rd_data;
  int         num_errors = 0;
  int         check_count = 0;
  int         go_cnt = 0;

  eeprom_cmd_write #(.WR_CYCLES(WR), .DSCHG_CYCLES(DS), .FACTORY_DATA(FACT),
    .IDENT_DATA(IDV)) eeprom_cmd_write_i (.CLK_SYS(clk_sys), .RESET(reset),
    .FRAME_START(fs), .FRAME_STOP(fp), .BIT_VALID(bv), .BIT_VALUE(bval),
    .SIO_IN(sio), .ANSWER_BIT(ans), .READ_GO(rgo), .READ_OPCODE(rop),
    .RD_OPCODE(rd_op), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .BUSY(busy),
    .SEC_LOCKED(lck), .ZONE_FROZEN(frz), .ZONE_ROM(zrom));
  host_model host_model_i (.clk(clk_sys), .frame_start(fs), .frame_stop(fp),
    .bit_valid(bv), .bit_value(bval), .sio_in(sio), .answer_bit(ans));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (rgo === 1'b1) go_cnt <= go_cnt + 1;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // answers land in ak: bit0 device byte, bit1 address byte, then data
  task automatic xfer(input logic [7:0] dev, mem, input int n, input logic [23:0] d);
    ak = 8'hFF;
    host_model_i.start_frame();
    host_model_i.send_byte(dev, 8, a);
    ak[0] = a;
    host_model_i.send_byte(mem, 8, a);
    ak[1] = a;
    for (int i = 0; i < n; i++) begin
      host_model_i.send_byte(d[8*i +: 8], 8, a);
      ak[i+2] = a;
    end
    host_model_i.stop_frame();
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk_sys) #1 n++;
      if (n > lim) begin
        chk(8'h00, 8'h01, "busy wait ran out");
        tally_and_finish();
      end
    end
  endtask
  task automatic rd(input logic [3:0] op, input logic [7:0] ad, exp, input string m);
    @(posedge clk_sys) #1 rd_op = op;
    rd_addr = ad;
    @(posedge clk_sys) #1 chk(rd_data, exp, m);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({ans, rgo, busy, lck, frz, 3'h0}, 8'h80, "reset outputs");
    chk({4'h0, zrom}, 8'h00, "reset zones");
    $display("test reset done");
  endtask
  task automatic t_byte();
    xfer(8'hA0, 8'h85, 1, 24'h00005A);
    chk(ak, 8'hF8, "byte write acks");
    chk({7'h0, busy}, 8'h01, "busy after stop");
    host_model_i.start_frame();
    host_model_i.send_byte(8'hA0, 8, a);
    chk({7'h0, a}, 8'h01, "busy answer");
    wait_idle(WR + 20);
    rd(4'hA, 8'h05, 8'h5A, "top bit ignored");
    $display("test byte done");
  endtask
  task automatic t_page();
    xfer(8'hA0, 8'h1E, 3, 24'h332211);
    chk(ak, 8'hE0, "page acks");
    wait_idle(WR + 20);
    rd(4'hA, 8'h1E, 8'h11, "page byte 0");
    rd(4'hA, 8'h1F, 8'h22, "page byte 1");
    rd(4'hA, 8'h18, 8'h33, "page wrap");
    $display("test page done");
  endtask
  task automatic t_abort();
    host_model_i.start_frame();
    host_model_i.send_byte(8'hA0, 8, a);
    host_model_i.send_byte(8'h05, 8, a);
    host_model_i.send_byte(8'hA5, 4, a);
    host_model_i.stop_frame();
    chk({7'h0, busy}, 8'h00, "mid byte stop");
    xfer(8'hA0, 8'h05, 0, 24'h0);
    chk({7'h0, busy}, 8'h00, "stop before data");
    rd(4'hA, 8'h05, 8'h5A, "abort kept data");
    $display("test abort done");
  endtask
  task automatic t_bad();
    xfer(8'h30, 8'h05, 1, 24'h000077);
    chk(ak, 8'hFF, "bad opcode silent");
    xfer(8'hA2, 8'h05, 1, 24'h000077);
    chk(ak, 8'hFF, "bad slave silent");
    chk({7'h0, busy}, 8'h00, "no write");
    rd(4'hA, 8'h05, 8'h5A, "data kept");
    $display("test bad done");
  endtask
  task automatic t_sec();
    xfer(8'hB0, 8'h10, 1, 24'h0000C3);
    chk(ak, 8'hF8, "security acks");
    wait_idle(WR + 20);
    rd(4'hB, 8'h10, 8'hC3, "security data");
    xfer(8'hB0, 8'h00, 1, 24'h000099);
    chk(ak, 8'hFC, "factory page refused");
    rd(4'hB, 8'h00, FACT[7:0], "factory byte");
    xfer(8'hC0, 8'h00, 1, 24'h000011);
    chk(ak, 8'hFC, "ident write refused");
    rd(4'hC, 8'h00, IDV[23:16], "ident 0");
    rd(4'hC, 8'h02, IDV[7:0], "ident 2");
    host_model_i.start_frame();
    host_model_i.send_byte(8'hA1, 8, a);
    host_model_i.stop_frame();
    chk({a, 3'h0, rop}, 8'h0A, "read hand-off");
    chk(go_cnt[7:0], 8'h01, "read go pulses");
    $display("test security done");
  endtask
  task automatic t_dschg();
    xfer(8'hA0, 8'h48, 1, 24'h000066);
    chk({7'h0, busy}, 8'h01, "write running");
    host_model_i.line_low(DS + 6);
    wait_idle(4);
    chk({7'h0, busy}, 8'h00, "terminated");
    $display("test discharge done");
  endtask
  task automatic t_zone();
    xfer(8'h70, 8'h01, 1, 24'h000001);
    chk(ak, 8'hF8, "zone set acks");
    wait_idle(WR + 20);
    chk({4'h0, zrom}, 8'h02, "zone one rom");
    rd(4'h7, 8'h01, 8'h01, "zone reg read");
    xfer(8'hA0, 8'h25, 1, 24'h000012);
    chk(ak, 8'hFC, "rom zone refused");
    xfer(8'h10, 8'h00, 1, 24'h000000);
    wait_idle(WR + 20);
    chk({7'h0, frz}, 8'h01, "frozen");
    xfer(8'h70, 8'h02, 1, 24'h000001);
    wait_idle(WR + 20);
    chk({4'h0, zrom}, 8'h02, "zones unchanged");
    $display("test zone done");
  endtask
  task automatic t_lock();
    xfer(8'h20, 8'h60, 1, 24'h000000);
    chk(ak, 8'hF8, "lock acks");
    wait_idle(WR + 20);
    chk({7'h0, lck}, 8'h01, "locked");
    xfer(8'hB0, 8'h10, 1, 24'h000044);
    chk(ak, 8'hFC, "locked refused");
    chk({7'h0, busy}, 8'h00, "no locked write");
    rd(4'hB, 8'h10, 8'hC3, "locked data kept");
    $display("test lock done");
  endtask

  initial begin
    reset = 1'b1;
    rd_op = 4'hA;
    rd_addr = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_reset();
    t_byte();
    t_page();
    t_abort();
    t_bad();
    t_sec();
    t_dschg();
    t_zone();
    t_lock();
    tally_and_finish();
  end
endmodule

// >>> dv/host_model.sv
// host master model driving decoded bit frames into the device
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic clk,
  // frames toward the device
  output logic      frame_start,
  output logic      frame_stop,
  output logic      bit_valid,
  output logic      bit_value,
  output logic      sio_in,
  // answer slot from the device
  input  wire logic answer_bit
);
  // line idles high on its pull-up, also through a write cycle
  initial begin
    frame_start = 1'b0;
    frame_stop  = 1'b0;
    bit_valid   = 1'b0;
    bit_value   = 1'b1;
    sio_in      = 1'b1;
  end
  task automatic start_frame();
    @(posedge clk) #1 frame_start = 1'b1;
    @(posedge clk) #1 frame_start = 1'b0;
  endtask
  // n below eight leaves the byte unfinished and skips the answer slot
  task automatic send_byte(input logic [7:0] b, input int n, output logic a);
    a = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk) #1 bit_valid = 1'b1;
      bit_value = b[i];
    end
    @(posedge clk) #1 bit_valid = 1'b0;
    // released line must not keep showing the last bit
    bit_value = ~bit_value;
    if (n == 8) begin
      @(posedge clk);
      @(posedge clk) #1 a = answer_bit;
      bit_valid = 1'b1;
      @(posedge clk) #1 bit_valid = 1'b0;
    end
  endtask
  // stop is an empty frame with the line left high
  task automatic stop_frame();
    @(posedge clk) #1 frame_stop = 1'b1;
    @(posedge clk) #1 frame_stop = 1'b0;
  endtask
  task automatic line_low(input int n);
    @(posedge clk) #1 sio_in = 1'b0;
    repeat (n) @(posedge clk);
    #1 sio_in = 1'b1;
  endtask
endmodule

// >>> logic/eep_defines.svh
// constants for the single-wire eeprom command and write block
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes held in the upper nibble of the device address byte
// ----------------------------------------------------------------
`define OPC_EEPROM        4'hA
`define OPC_SECURITY      4'hB
`define OPC_LOCK          4'h2
`define OPC_ZONE          4'h7
`define OPC_FREEZE        4'h1
`define OPC_IDENT         4'hC

// ----------------------------------------------------------------
// organisation
// ----------------------------------------------------------------
`define PAGE_COUNT        16
`define PAGE_BYTES        8
`define MAIN_BYTES        128
`define SEC_USER_BYTES    16
`define ZONE_COUNT        4
`define LOCK_ADDR_KEY     4'h6

// ----------------------------------------------------------------
// answer bit values and reset values
// ----------------------------------------------------------------
`define ACK_BIT           1'b0
`define NACK_BIT          1'b1
`define ADDR_RESET        8'h00
`define BYTE_RESET        8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ           100
`define WRITE_CYCLE_MS    5
`define DSCHG_TIME_US     150

`endif

// >>> logic/eep_pkg.sv
// types shared by the eeprom command block and its write timer
package eep_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_DEVADDR = 6'h02,
    ST_MEMADDR = 6'h04,
    ST_DATA    = 6'h08,
    ST_STANDBY = 6'h10,
    ST_BUSY    = 6'h20
  } state_t;

  typedef enum logic [2:0] {
    WK_NONE   = 3'h0,
    WK_MAIN   = 3'h1,
    WK_SEC    = 3'h2,
    WK_LOCK   = 3'h3,
    WK_ZONE   = 3'h4,
    WK_FREEZE = 3'h5
  } write_kind_t;

endpackage

// >>> logic/eeprom_cmd_write.sv
// command decoder and write engine of a single-wire serial eeprom
//
// What this block does
// - main array is sixteen pages of eight
// - security region four pages, lower two fixed
// - upper security pages writable until locked
// - opcodes 1010 main, 1011 security access
// - opcode 0010 locks, 0001 freezes zones
// - opcode 0111 zone register, 1100 identification
// - four zones, each settable read-only
// - after freeze zone state cannot change
// - identification returns maker, density, revision
// - stop off byte boundary aborts, programs nothing
// - busy ignores commands and answers nack
// - long low during write terminates it
// - byte write acks each of three bytes
// - idle-high empty frame is the stop
// - valid stop starts timed write cycle
// - page writes one to eight bytes
// - ack every data byte, with no limit at eight
// - only low three address bits increment
// - top address bit ignored for main array
// - address byte is opcode, slave bits, direction
// - bad opcode or slave address stays silent
// - ack is logic zero, nack logic one
`timescale 1ns/1ps
`include "eep_defines.svh"
module eeprom_cmd_write #(
  parameter logic [2:0]   SLAVE_ADDR   = 3'h0,
  // arbitrary value for the factory pages
  parameter logic [127:0] FACTORY_DATA = 128'h0123456789ABCDEF0011223344556677,
  // arbitrary value for the identification bytes
  parameter logic [23:0]  IDENT_DATA   = 24'h5A1010,
  parameter int           WR_CYCLES    = `WRITE_CYCLE_MS * 1000 * `CLK_MHZ,
  parameter int           DSCHG_CYCLES = `DSCHG_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  // decoded frames from the bit-frame layer
  input  wire logic           FRAME_START,
  input  wire logic           FRAME_STOP,
  input  wire logic           BIT_VALID,
  input  wire logic           BIT_VALUE,
  // raw line level, used to time a discharge
  input  wire logic           SIO_IN,
  // bit to give in the next output frame
  output logic                ANSWER_BIT,
  // hand-off to the read engine
  output logic                READ_GO,
  output logic [3:0]          READ_OPCODE,
  input  wire logic [3:0]     RD_OPCODE,
  input  wire logic [7:0]     RD_ADDR,
  output eep_pkg::byte_t      RD_DATA,
  // status
  output logic                BUSY,
  output logic                SEC_LOCKED,
  output logic                ZONE_FROZEN,
  output logic [3:0]          ZONE_ROM
);
  import eep_pkg::*;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  state_t      state_reg;
  write_kind_t kind_reg;
  logic [3:0]  bit_cnt_reg;
  byte_t       shift_reg;
  byte_t       addr_reg;
  logic [1:0]  zone_idx_reg;
  logic        got_byte_reg;
  // the zone byte sits at its own buffer slot, so its set bit is kept here
  logic        zone_set_reg;
  logic        sio_s1_reg;
  logic        sio_s2_reg;
  logic        sec_locked_reg;
  logic        zone_frozen_reg;
  logic [3:0]  zone_rom_reg;
  byte_t       page_buf [`PAGE_BYTES];
  logic        buf_valid [`PAGE_BYTES];
  byte_t       main_mem [`MAIN_BYTES];
  byte_t       sec_user [`SEC_USER_BYTES];

  logic        byte_done;
  logic        ack_slot;
  byte_t       rx_byte;
  logic        opc_ok;
  logic        dev_ok;
  logic        mem_ok;
  logic        data_ok;
  logic        data_take;
  logic        valid_stop;
  write_kind_t kind_next;
  logic [127:0] fact_shift;

  wcycle_if wc ();

  assign byte_done = BIT_VALID && bit_cnt_reg == 4'h7;
  assign ack_slot  = BIT_VALID && bit_cnt_reg == 4'h8;
  assign rx_byte   = {shift_reg[6:0], BIT_VALUE};

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    kind_next = WK_NONE;
    opc_ok    = 1'b1;
    case (rx_byte[7:4])
      `OPC_EEPROM:   kind_next = WK_MAIN;
      `OPC_SECURITY: kind_next = WK_SEC;
      `OPC_LOCK:     kind_next = WK_LOCK;
      `OPC_FREEZE:   kind_next = WK_FREEZE;
      `OPC_ZONE:     kind_next = WK_ZONE;
      `OPC_IDENT:    kind_next = WK_NONE;
      default:       opc_ok    = 1'b0;
    endcase
  end

  assign dev_ok = opc_ok && rx_byte[3:1] == SLAVE_ADDR;
  assign mem_ok = (kind_reg != WK_LOCK)
               || (!sec_locked_reg && rx_byte[7:4] == `LOCK_ADDR_KEY);

  always_comb begin
    case (kind_reg)
      WK_MAIN:   data_ok = !zone_rom_reg[addr_reg[6:5]];
      WK_SEC:    data_ok = !sec_locked_reg && addr_reg[4];
      WK_LOCK:   data_ok = !sec_locked_reg;
      WK_ZONE:   data_ok = !zone_frozen_reg;
      WK_FREEZE: data_ok = !zone_frozen_reg;
      default:   data_ok = 1'b0;
    endcase
  end

  assign data_take  = byte_done && state_reg == ST_DATA && data_ok;
  // an empty idle-high frame at a byte boundary after an accepted byte
  assign valid_stop = FRAME_STOP && state_reg == ST_DATA
                   && bit_cnt_reg == 4'h0 && got_byte_reg;

  assign wc.start    = valid_stop;
  assign wc.line_low = !sio_s2_reg;

  // ----------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      sio_s1_reg <= 1'b1;
      sio_s2_reg <= 1'b1;
    end else begin
      sio_s1_reg <= SIO_IN;
      sio_s2_reg <= sio_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // bit counter: eight data bits then one answer frame
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET || FRAME_START || FRAME_STOP) begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= `BYTE_RESET;
    end else if (BIT_VALID) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
      shift_reg   <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // command sequence
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_BUSY: begin
          // frames during the write cycle are not recognised
          if (wc.done || wc.terminated) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          if (FRAME_START) begin
            state_reg <= ST_DEVADDR;
          end else if (FRAME_STOP) begin
            state_reg <= valid_stop ? ST_BUSY : ST_IDLE;
          end else if (byte_done) begin
            case (state_reg)
              ST_DEVADDR: state_reg <= (dev_ok && !rx_byte[0]) ? ST_MEMADDR : ST_STANDBY;
              ST_MEMADDR: state_reg <= mem_ok ? ST_DATA : ST_STANDBY;
              ST_DATA:    state_reg <= data_ok ? ST_DATA : ST_STANDBY;
              default:    state_reg <= state_reg;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // answer bit for the frame after each byte
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET || state_reg == ST_BUSY || FRAME_START || FRAME_STOP) begin
      ANSWER_BIT <= `NACK_BIT;
    end else if (byte_done) begin
      case (state_reg)
        ST_DEVADDR: ANSWER_BIT <= dev_ok ? `ACK_BIT : `NACK_BIT;
        ST_MEMADDR: ANSWER_BIT <= mem_ok ? `ACK_BIT : `NACK_BIT;
        ST_DATA:    ANSWER_BIT <= data_ok ? `ACK_BIT : `NACK_BIT;
        default:    ANSWER_BIT <= `NACK_BIT;
      endcase
    end else if (ack_slot) begin
      // data frames after the answer must not be pulled low
      ANSWER_BIT <= `NACK_BIT;
    end
  end

  // ----------------------------------------------------------------
  // command capture and address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    READ_GO <= 1'b0;
    if (RESET) begin
      kind_reg     <= WK_NONE;
      addr_reg     <= `ADDR_RESET;
      zone_idx_reg <= 2'h0;
      got_byte_reg <= 1'b0;
      zone_set_reg <= 1'b0;
      READ_OPCODE  <= 4'h0;
    end else if (state_reg != ST_BUSY) begin
      if (FRAME_START) begin
        got_byte_reg <= 1'b0;
        zone_set_reg <= 1'b0;
      end else if (byte_done && state_reg == ST_DEVADDR && dev_ok) begin
        kind_reg    <= rx_byte[0] ? WK_NONE : kind_next;
        READ_OPCODE <= rx_byte[7:4];
        READ_GO     <= rx_byte[0];
      end else if (byte_done && state_reg == ST_MEMADDR) begin
        addr_reg     <= rx_byte;
        zone_idx_reg <= rx_byte[1:0];
      end else if (data_take) begin
        // the page stays fixed and the pointer rolls over inside it
        addr_reg     <= {addr_reg[7:3], addr_reg[2:0] + 3'h1};
        got_byte_reg <= 1'b1;
        zone_set_reg <= (kind_reg == WK_ZONE) && rx_byte[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer, one entry per low address value
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `PAGE_BYTES; i++) begin : g_buf
    always_ff @(posedge CLK_SYS) begin
      if (RESET || (FRAME_START && state_reg != ST_BUSY)) begin
        buf_valid[i] <= 1'b0;
        page_buf[i]  <= `BYTE_RESET;
      end else if (data_take && addr_reg[2:0] == 3'(i)) begin
        buf_valid[i] <= 1'b1;
        page_buf[i]  <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // arrays: loaded buffer entries go in when the write cycle starts
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (valid_stop) begin
      for (int j = 0; j < `PAGE_BYTES; j++) begin
        if (buf_valid[j] && kind_reg == WK_MAIN) begin
          main_mem[{addr_reg[6:3], 3'(j)}] <= page_buf[j];
        end
        if (buf_valid[j] && kind_reg == WK_SEC) begin
          sec_user[{addr_reg[3], 3'(j)}] <= page_buf[j];
        end
      end
    end
  end

  // configuration bits change only when the cycle runs to its end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      sec_locked_reg  <= 1'b0;
      zone_frozen_reg <= 1'b0;
      zone_rom_reg    <= 4'h0;
    end else if (wc.done) begin
      case (kind_reg)
        WK_LOCK:   sec_locked_reg <= 1'b1;
        WK_FREEZE: zone_frozen_reg <= 1'b1;
        WK_ZONE: begin
          if (!zone_frozen_reg && zone_set_reg) begin
            zone_rom_reg[zone_idx_reg] <= 1'b1;
          end
        end
        default: zone_rom_reg <= zone_rom_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read port for the read engine
  // ----------------------------------------------------------------
  assign fact_shift = FACTORY_DATA >> {RD_ADDR[3:0], 3'b000};

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      RD_DATA <= `BYTE_RESET;
    end else begin
      case (RD_OPCODE)
        `OPC_EEPROM:   RD_DATA <= main_mem[RD_ADDR[6:0]];
        `OPC_SECURITY: RD_DATA <= RD_ADDR[4] ? sec_user[RD_ADDR[3:0]] : fact_shift[7:0];
        `OPC_ZONE:     RD_DATA <= {7'h00, zone_rom_reg[RD_ADDR[1:0]]};
        `OPC_IDENT:    RD_DATA <= (RD_ADDR[1:0] == 2'h0) ? IDENT_DATA[23:16] :
                                  (RD_ADDR[1:0] == 2'h1) ? IDENT_DATA[15:8] :
                                  IDENT_DATA[7:0];
        default:       RD_DATA <= `BYTE_RESET;
      endcase
    end
  end

  assign BUSY        = state_reg == ST_BUSY;
  assign SEC_LOCKED  = sec_locked_reg;
  assign ZONE_FROZEN = zone_frozen_reg;
  assign ZONE_ROM    = zone_rom_reg;

  write_timer #(
    .WR_CYCLES    (WR_CYCLES),
    .DSCHG_CYCLES (DSCHG_CYCLES)
  ) u_timer (
    .clk (CLK_SYS),
    .rst (RESET),
    .wc  (wc.timer)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_stop_starts_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
    valid_stop |=> BUSY ##1 wc.busy)
    else $error("valid stop did not start the write cycle");

  a_bad_stop_abort: assert property (@(posedge CLK_SYS) disable iff (RESET)
    FRAME_STOP && !valid_stop && !BUSY |=> state_reg == ST_IDLE && !wc.busy)
    else $error("stop off a byte boundary did not abort");

  a_addr_wrap_page: assert property (@(posedge CLK_SYS) disable iff (RESET)
    data_take |=> addr_reg[7:3] == $past(addr_reg[7:3])
              && addr_reg[2:0] == $past(addr_reg[2:0]) + 3'h1)
    else $error("pointer left its page or did not step");

  a_commit_buffer: assert property (@(posedge CLK_SYS) disable iff (RESET)
    valid_stop && kind_reg == WK_MAIN && buf_valid[0]
    |=> main_mem[{$past(addr_reg[6:3]), 3'h0}] == $past(page_buf[0]))
    else $error("buffered byte not written at stop");

  a_busy_nack: assert property (@(posedge CLK_SYS) disable iff (RESET)
    BUSY && $past(BUSY) |-> ANSWER_BIT == `NACK_BIT && !READ_GO)
    else $error("busy device answered a command");

  a_bad_addr_silent: assert property (@(posedge CLK_SYS) disable iff (RESET)
    byte_done && state_reg == ST_DEVADDR && !dev_ok
    |=> ANSWER_BIT == `NACK_BIT && state_reg == ST_STANDBY)
    else $error("mismatched address was acknowledged");

  a_write_opcode_ack: assert property (@(posedge CLK_SYS) disable iff (RESET)
    byte_done && state_reg == ST_DEVADDR && dev_ok && !rx_byte[0]
    && (rx_byte[7:4] == `OPC_EEPROM || rx_byte[7:4] == `OPC_SECURITY)
    |=> ANSWER_BIT == `ACK_BIT && state_reg == ST_MEMADDR)
    else $error("write address byte not acknowledged");

  a_locked_refuse: assert property (@(posedge CLK_SYS) disable iff (RESET)
    byte_done && state_reg == ST_DATA && kind_reg == WK_SEC && sec_locked_reg
    |=> ANSWER_BIT == `NACK_BIT ##1 !got_byte_reg || state_reg != ST_DATA)
    else $error("locked security data byte accepted");

  a_frozen_zones: assert property (@(posedge CLK_SYS) disable iff (RESET)
    zone_frozen_reg |=> $stable(zone_rom_reg) && zone_frozen_reg)
    else $error("zone state changed after freeze");

  a_factory_pages: assert property (@(posedge CLK_SYS) disable iff (RESET)
    valid_stop && kind_reg == WK_SEC |-> addr_reg[4] && !sec_locked_reg)
    else $error("write aimed at factory security pages");

endmodule

// >>> logic/wcycle_if.sv
// handshake between the command block and the self-timed write cycle
`timescale 1ns/1ps
interface wcycle_if;
  logic start;
  logic line_low;
  logic busy;
  logic done;
  logic terminated;

  modport ctrl  (output start, output line_low, input busy, input done, input terminated);
  modport timer (input start, input line_low, output busy, output done, output terminated);
endinterface

// >>> logic/write_timer.sv
// self-timed nonvolatile write cycle with discharge termination
`timescale 1ns/1ps
module write_timer #(
  parameter int WR_CYCLES    = 500000,
  parameter int DSCHG_CYCLES = 15000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // write cycle handshake
  wcycle_if.timer   wc
);
  import eep_pkg::*;

  localparam int WW = $clog2(WR_CYCLES + 1);
  localparam int DW = $clog2(DSCHG_CYCLES + 1);
  localparam logic [WW-1:0] WR_LAST = WW'(WR_CYCLES - 1);
  localparam logic [DW-1:0] DS_LAST = DW'(DSCHG_CYCLES - 1);

  logic          busy_reg;
  logic          done_reg;
  logic          term_reg;
  logic [WW-1:0] wr_cnt_reg;
  logic [DW-1:0] low_cnt_reg;
  logic          low_hit;

  assign low_hit       = busy_reg && wc.line_low && (low_cnt_reg == DS_LAST);
  assign wc.busy       = busy_reg;
  assign wc.done       = done_reg;
  assign wc.terminated = term_reg;

  // ----------------------------------------------------------------
  // cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    done_reg <= 1'b0;
    term_reg <= 1'b0;
    if (rst) begin
      busy_reg   <= 1'b0;
      wr_cnt_reg <= '0;
    end else if (wc.start && !busy_reg) begin
      busy_reg   <= 1'b1;
      wr_cnt_reg <= '0;
    end else if (busy_reg) begin
      if (low_hit) begin
        busy_reg <= 1'b0;
        term_reg <= 1'b1;
      end else if (wr_cnt_reg == WR_LAST) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end else begin
        wr_cnt_reg <= wr_cnt_reg + WW'(1);
      end
    end
  end

  // a low line only drains storage when it stays low without a break
  always_ff @(posedge clk) begin
    if (rst || !busy_reg || !wc.line_low) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != DS_LAST) begin
      low_cnt_reg <= low_cnt_reg + DW'(1);
    end
  end

  a_done_full_time: assert property (@(posedge clk) disable iff (rst)
    done_reg |-> $past(wr_cnt_reg) == WR_LAST && !busy_reg)
    else $error("write cycle ended before its full time");

  a_discharge_term: assert property (@(posedge clk) disable iff (rst)
    term_reg |-> $past(low_cnt_reg) == DS_LAST && $past(wc.line_low))
    else $error("write cycle terminated without a full discharge");

endmodule
